// ==== design/lpx_bridge.sv ====
// Link to PCI-X bridge translation core with register slave
`timescale 1ns/100ps
module lpx_bridge
  import lpx_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        link_clk,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        lk_valid,
  input  wire link_req_t   lk_req,
  output logic             lk_ready,
  output logic             lo_valid,
  output lout_t            lo_pkt,
  output logic             px_valid,
  output pcix_cmd_t        px_cmd,
  input  wire logic        px_ready,
  input  wire logic        up_valid,
  input  wire up_t         up_in,
  output logic             up_ready
);

  typedef enum logic {S_IDLE, S_DIM} dim_st_t;

  ////////////////////////////////////////////////////////////////
  // Link domain: reset, request capture, response emission
  logic [1:0] lrst_s;
  link_req_t  li_hold_r;
  logic       li_tgl_r;
  logic [1:0] li_ack_s;
  logic       lk_ready_r;
  logic [1:0] lo_s;
  logic       lo_seen_r;
  logic       lo_valid_r;
  lout_t      lo_pkt_r;
  lout_t      lo_hold_r;
  logic       lo_tgl_r;
  logic       ci_seen_r;
  logic [3:0] lrq_cnt_r;
  logic       lrun_r;

  wire lrst_n  = lrst_s[1];
  wire li_take = lk_valid & lk_ready_r;

  // Stretched reset reaches the link domain through two stages
  always_ff @(posedge link_clk) begin
    lrst_s <= {lrst_s[0], lrun_r};
  end

  // Held word stays frozen until the core toggles back
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      li_ack_s   <= 2'b00;
      li_tgl_r   <= 1'b0;
      lk_ready_r <= 1'b0;
      li_hold_r  <= '0;
    end else begin
      li_ack_s   <= {li_ack_s[0], ci_seen_r};
      lk_ready_r <= !li_take && (li_tgl_r == li_ack_s[1]);
      if (li_take) begin
        li_hold_r <= lk_req;
        li_tgl_r  <= ~li_tgl_r;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      lo_s       <= 2'b00;
      lo_seen_r  <= 1'b0;
      lo_valid_r <= 1'b0;
      lo_pkt_r   <= '0;
    end else begin
      lo_s       <= {lo_s[0], lo_tgl_r};
      lo_valid_r <= lo_s[1] != lo_seen_r;
      lo_seen_r  <= lo_s[1];
      if (lo_s[1] != lo_seen_r) begin
        lo_pkt_r <= lo_hold_r;
      end
    end
  end

  assign lk_ready = lk_ready_r;
  assign lo_valid = lo_valid_r;
  assign lo_pkt   = lo_pkt_r;

  ////////////////////////////////////////////////////////////////
  // Core domain: register slave
  logic [2:0]  ctrl_r;
  logic [11:0] mbase_r;
  logic        wait_r;
  logic [31:0] rdata_r;
  logic [SEQ_N-1:0] busy_r;
  dim_st_t     st_r;
  logic [1:0]  ci_s;
  logic [1:0]  co_s;

  wire sel_ctrl  = avs_address == OFS_CTRL;
  wire sel_mbase = avs_address == OFS_MBASE;
  wire sel_stat  = avs_address == OFS_STAT;
  wire wr_go     = avs_write & ~wait_r;
  wire lo_busy   = lo_tgl_r != co_s[1];
  wire pend      = ci_s[1] != ci_seen_r;
  wire [31:0] stat_w = {busy_r, 13'h0000, st_r == S_DIM, pend, lo_busy};
  wire [31:0] rd_mux = sel_ctrl  ? {29'h00000000, ctrl_r} :
                       sel_mbase ? {mbase_r, 20'h00000} :
                       sel_stat  ? stat_w : 32'h00000000;

  // One wait cycle per access; unmapped reads give zero
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wait_r  <= 1'b1;
      rdata_r <= '0;
      ctrl_r  <= CTRL_RST;
      mbase_r <= MBASE_RST;
    end else begin
      wait_r <= ~((avs_read | avs_write) & wait_r);
      if (avs_read & wait_r) begin
        rdata_r <= rd_mux;
      end
      if (wr_go & sel_ctrl) begin
        ctrl_r <= avs_writedata[2:0];
      end
      if (wr_go & sel_mbase) begin
        mbase_r <= avs_writedata[31:20];
      end
    end
  end

  // Link side stays in reset long enough to see several of its own edges
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      lrq_cnt_r <= '0;
      lrun_r    <= 1'b0;
    end else begin
      lrun_r <= lrun_r | (lrq_cnt_r == LRST_CYC);
      if (!lrun_r) begin
        lrq_cnt_r <= lrq_cnt_r + 4'h1;
      end
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata    = rdata_r;

  ////////////////////////////////////////////////////////////////
  // Core domain: link request translation
  logic       px_valid_r;
  pcix_cmd_t  px_cmd_r;
  pcix_cmd_t  cmd_nxt;
  logic       up_ready_r;

  link_req_t rq;
  assign rq = li_hold_r;

  wire perr_en = ctrl_r[CTL_PERR];
  wire ecc_md  = ctrl_r[CTL_ECC];
  wire np_req  = (rq.kind == LK_READ) || (rq.kind == LK_WRITE && !rq.posted);
  wire is_abt  = (rq.err == ER_TABORT) || (rq.err == ER_MABORT);
  wire is_xcfg = rq.kind == LK_WRITE && rq.posted && rq.space == SP_XCFG;
  wire blk     = np_req && rq.seq != 4'h0 && busy_r[rq.seq]; // R19
  wire go      = pend & px_ready & ~blk & ~px_valid_r;
  wire up_take = up_valid & up_ready_r;
  wire cpl_clr = up_take && up_in.kind == UP_CPL;
  wire msi_hit = up_in.addr[31:20] == mbase_r && ctrl_r[CTL_MSI];

  always_comb begin
    cmd_nxt      = '0;
    cmd_nxt.ro   = rq.ro;
    cmd_nxt.seq  = rq.seq;
    cmd_nxt.addr = rq.addr;
    cmd_nxt.data = rq.data;
    // Corrupt data travels on with poisoned check bits
    cmd_nxt.badpar = rq.derr || (rq.kind == LK_RD_RESP && rq.err == ER_DATA); // R5
    cmd_nxt.stomp  = cmd_nxt.badpar && ecc_md; // R5
    case (rq.kind)
      LK_RD_RESP, LK_TGT_DONE: begin
        if (is_abt) begin
          cmd_nxt.kind = PX_SCM; // R3
          cmd_nxt.cls  = CLS_BRIDGE;
          cmd_nxt.idx  = rq.err == ER_TABORT ? IDX_TABORT : IDX_MABORT;
        end else if (rq.kind == LK_RD_RESP) begin
          cmd_nxt.kind = PX_SRC; // R1
        end else if (rq.err == ER_DATA && perr_en) begin
          cmd_nxt.kind = PX_SCM; // R4
          cmd_nxt.cls  = CLS_BRIDGE;
          cmd_nxt.idx  = IDX_DERR;
        end else begin
          cmd_nxt.kind   = PX_IWC; // R2
          cmd_nxt.badpar = 1'b0;
          cmd_nxt.stomp  = 1'b0;
          cmd_nxt.perr   = rq.derr && perr_en; // R6
        end
      end
      LK_WRITE: begin
        cmd_nxt.ro      = rq.ppw;
        cmd_nxt.nosnoop = !rq.coh;
        cmd_nxt.more    = rq.chain;
        if (st_r == S_DIM) begin
          cmd_nxt.kind = PX_DIMD; // R13
        end else if (is_xcfg) begin
          cmd_nxt.kind   = PX_DIMH; // R9
          cmd_nxt.route  = rq.addr[4]; // R10
          cmd_nxt.sdrop  = rq.addr[3];
          cmd_nxt.ireq   = rq.addr[2];
          cmd_nxt.mcls0  = rq.addr[5];
          cmd_nxt.bcnt   = {rq.addr[27:24], rq.data[23:16]}; // R11
          cmd_nxt.rid    = rq.data[15:0];
          cmd_nxt.csa_lo = rq.data[31:24]; // R12
          cmd_nxt.csa_hi = rq.data[63:32];
        end else if (rq.space == SP_MEM) begin
          cmd_nxt.kind    = PX_PMW; // R7
          cmd_nxt.needcpl = !rq.posted;
        end else begin
          cmd_nxt.kind    = PX_SWR; // R8
          cmd_nxt.needcpl = 1'b1;
        end
      end
      LK_READ: begin
        cmd_nxt.kind    = PX_SRR; // R8
        cmd_nxt.nosnoop = !rq.coh;
        cmd_nxt.needcpl = 1'b1;
      end
      default: begin
        cmd_nxt.kind = PX_SRC;
      end
    endcase
  end

  // Message data beats follow while the chain flag stays set
  always_ff @(posedge core_clk) begin
    // Held at zero until the link side has left reset
    ci_s <= (nrst && lrun_r) ? {ci_s[0], li_tgl_r} : 2'b00;
    if (!nrst) begin
      ci_seen_r  <= 1'b0;
      px_valid_r <= 1'b0;
      px_cmd_r   <= '0;
      st_r       <= S_IDLE;
    end else begin
      px_valid_r <= go;
      if (go) begin
        ci_seen_r <= ci_s[1];
        px_cmd_r  <= cmd_nxt;
        if (rq.kind == LK_WRITE) begin
          case (st_r)
            S_IDLE:  st_r <= (is_xcfg && rq.chain) ? S_DIM : S_IDLE; // R13
            S_DIM:   st_r <= rq.chain ? S_DIM : S_IDLE;
            default: st_r <= S_IDLE;
          endcase
        end
      end
    end
  end

  // Set beats clear so a same-cycle completion cannot free a new issue
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      busy_r <= '0;
    end else begin
      for (int i = 0; i < SEQ_N; i++) begin
        if (go && np_req && rq.seq != 4'h0 && rq.seq == 4'(i)) begin
          busy_r[i] <= 1'b1; // R19
        end else if (cpl_clr && up_in.seq == 4'(i)) begin
          busy_r[i] <= 1'b0;
        end
      end
    end
  end

  assign px_valid = px_valid_r;
  assign px_cmd   = px_cmd_r;

  ////////////////////////////////////////////////////////////////
  // Core domain: completions and MSI toward the link
  wire [63:0] ii_w = {8'h00, up_in.data[14:11], up_in.addr[3],
                      up_in.addr[30:20], up_in.addr[11:4], INTR_HI,
                      up_in.data[7:0], up_in.addr[19:12], 1'b0,
                      up_in.addr[2], up_in.data[15], up_in.data[10:8], 2'b00};

  // Only one word in flight; ready drops until the link side acks
  always_ff @(posedge core_clk) begin
    co_s <= (nrst && lrun_r) ? {co_s[0], lo_seen_r} : 2'b00;
    if (!nrst) begin
      up_ready_r <= 1'b0;
      lo_tgl_r   <= 1'b0;
      lo_hold_r  <= '0;
    end else begin
      up_ready_r <= lrun_r && !up_take && !lo_busy;
      if (up_take && up_in.kind == UP_CPL) begin
        lo_hold_r.kind  <= up_in.rd ? LO_RD_RESP : LO_TGT_DONE; // R7 R8
        lo_hold_r.derr  <= up_in.derr;
        lo_hold_r.seq   <= up_in.seq;
        lo_hold_r.data  <= up_in.data;
        lo_hold_r.iinfo <= '0;
        lo_tgl_r        <= ~lo_tgl_r;
      end else if (up_take && msi_hit) begin
        lo_hold_r.kind  <= LO_INTR; // R14
        lo_hold_r.derr  <= 1'b0;
        lo_hold_r.seq   <= 4'h0;
        lo_hold_r.data  <= '0;
        lo_hold_r.iinfo <= ii_w; // R15 R16 R18
        lo_tgl_r        <= ~lo_tgl_r;
      end
    end
  end

  assign up_ready = up_ready_r;

  ////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_src_ro;
    go && rq.kind == LK_RD_RESP && rq.err == ER_NONE |=>
      px_valid_r && px_cmd_r.kind == PX_SRC && px_cmd_r.ro == $past(rq.ro);
  endproperty
  a_src_ro: assert property (p_src_ro) else $error("read completion lost RO"); // R1

  property p_iwc_perr;
    go && rq.kind == LK_TGT_DONE && rq.err == ER_NONE |=>
      px_cmd_r.kind == PX_IWC && px_cmd_r.perr == ($past(rq.derr) && $past(perr_en));
  endproperty
  a_iwc_perr: assert property (p_iwc_perr) else $error("write completion PERR wrong"); // R2

  property p_abort_idx;
    go && is_abt |=> px_cmd_r.kind == PX_SCM && px_cmd_r.cls == CLS_BRIDGE &&
      px_cmd_r.idx == ($past(rq.err) == ER_TABORT ? IDX_TABORT : IDX_MABORT);
  endproperty
  a_abort_idx: assert property (p_abort_idx) else $error("abort class or index wrong"); // R3

  property p_derr_msg;
    $rose(px_valid_r) && px_cmd_r.kind == PX_SCM && px_cmd_r.idx == IDX_DERR |->
      $past(rq.kind) == LK_TGT_DONE && $past(perr_en);
  endproperty
  a_derr_msg: assert property (p_derr_msg) else $error("data error message misused"); // R4

  property p_stomp;
    go && rq.derr && rq.kind != LK_TGT_DONE |=> px_cmd_r.badpar && px_cmd_r.stomp == $past(ecc_md);
  endproperty
  a_stomp: assert property (p_stomp) else $error("corrupt data not poisoned"); // R5

  property p_perr_gate;
    $rose(px_valid_r) && px_cmd_r.perr |-> $past(perr_en);
  endproperty
  a_perr_gate: assert property (p_perr_gate) else $error("PERR without enable"); // R6

  property p_np_cpl;
    go && np_req |=> px_cmd_r.needcpl;
  endproperty
  a_np_cpl: assert property (p_np_cpl) else $error("nonposted request not tracked"); // R7 R8

  property p_dim_map;
    go && st_r == S_IDLE && is_xcfg |=> px_cmd_r.kind == PX_DIMH &&
      px_cmd_r.route == $past(rq.addr[4]) && px_cmd_r.mcls0 == $past(rq.addr[5]) &&
      px_cmd_r.bcnt == {$past(rq.addr[27:24]), $past(rq.data[23:16])} &&
      px_cmd_r.csa_lo == $past(rq.data[31:24]) && px_cmd_r.ro == $past(rq.ppw);
  endproperty
  a_dim_map: assert property (p_dim_map) else $error("message header mapping wrong"); // R9 R10 R11 R12

  sequence s_dim_open;
    go && st_r == S_IDLE && is_xcfg && rq.chain;
  endsequence
  sequence s_dim_beat;
    go && st_r == S_DIM && rq.kind == LK_WRITE;
  endsequence
  property p_dim_chain;
    s_dim_open |=> st_r == S_DIM;
  endproperty
  a_dim_chain: assert property (p_dim_chain) else $error("message data phase not entered"); // R13

  property p_dim_data;
    s_dim_beat |=> px_cmd_r.kind == PX_DIMD && px_cmd_r.data == $past(rq.data) &&
      px_cmd_r.more == $past(rq.chain);
  endproperty
  a_dim_data: assert property (p_dim_data) else $error("message data beat wrong"); // R13

  property p_intr_map;
    up_take && up_in.kind == UP_MWR && msi_hit |=> lo_hold_r.kind == LO_INTR &&
      lo_hold_r.iinfo[23:16] == $past(up_in.data[7:0]) &&
      lo_hold_r.iinfo[15:8] == $past(up_in.addr[19:12]) &&
      lo_hold_r.iinfo[31:24] == INTR_HI && !lo_hold_r.iinfo[7];
  endproperty
  a_intr_map: assert property (p_intr_map) else $error("interrupt info mapping wrong"); // R14 R15 R18

  property p_seq_busy;
    go && np_req && rq.seq != 4'h0 |=> busy_r[$past(rq.seq)];
  endproperty
  a_seq_busy: assert property (p_seq_busy) else $error("sequence not held busy"); // R19

endmodule

// ==== design/lpx_pkg.sv ====
// Package: constants and carrier types of the link to PCI-X bridge
// Functional notes
// R1 - read_response becomes read completion, keeps RO
// R2 - target_done becomes immediate write completion, PERR
// R3 - Abort errors give class 1 message, index
// R4 - Data-error message only for target_done, enabled
// R5 - Flagged data sent with bad parity/ECC
// R6 - PERR gated by parity error response enable
// R7 - Nonposted memory write posted, done after phases
// R8 - Config and I/O never posted, always answered
// R9 - Extended config write becomes device_id_message
// R10 - Message routing bits taken from address
// R11 - Byte count and requestor ID mapping
// R12 - Class-specific address taken from data
// R13 - Chain flag marks message data writes
// R14 - MSI write in window becomes interrupt
// R15 - Destination assembled from MSI address/data
// R16 - message_type carried in interrupt_info 4:2
// R17 - Software keeps request_eoi zero
// R18 - interrupt_info bit 7 zero, 31:24 F8h
// R19 - Same nonzero sequence_id requests complete in order
package lpx_pkg;
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_MBASE  = 5'h04;
  localparam logic [4:0] OFS_STAT   = 5'h08;
  localparam int         CTL_PERR   = 0;
  localparam int         CTL_ECC    = 1;
  localparam int         CTL_MSI    = 2;
  localparam logic [2:0] CTRL_RST   = 3'h5;
  localparam logic [11:0] MBASE_RST = 12'h000;
  localparam logic [1:0] CLS_BRIDGE = 2'h1;
  localparam logic [7:0] IDX_MABORT = 8'h00;
  localparam logic [7:0] IDX_TABORT = 8'h01;
  localparam logic [7:0] IDX_DERR   = 8'h02;
  localparam logic [7:0] INTR_HI    = 8'hF8;
  localparam int         SEQ_N      = 16;
  localparam logic [3:0] LRST_CYC   = 4'hC;

  typedef enum logic [1:0] {LK_RD_RESP, LK_TGT_DONE, LK_WRITE, LK_READ} lk_kind_t;
  typedef enum logic [1:0] {ER_NONE, ER_DATA, ER_TABORT, ER_MABORT} err_t;
  typedef enum logic [1:0] {SP_MEM, SP_IO, SP_CFG, SP_XCFG} space_t;
  typedef enum logic [2:0] {PX_SRC, PX_IWC, PX_SCM, PX_PMW, PX_SWR, PX_SRR, PX_DIMH, PX_DIMD} px_kind_t;
  typedef enum logic {UP_CPL, UP_MWR} up_kind_t;
  typedef enum logic [1:0] {LO_RD_RESP, LO_TGT_DONE, LO_INTR} lo_kind_t;

  typedef struct packed {
    lk_kind_t    kind;
    err_t        err;
    logic        derr;
    logic        ro;
    logic        posted;
    space_t      space;
    logic        chain;
    logic        ppw;
    logic        coh;
    logic [3:0]  seq;
    logic [31:0] addr;
    logic [63:0] data;
  } link_req_t;

  typedef struct packed {
    px_kind_t    kind;
    logic        ro;
    logic        nosnoop;
    logic        perr;
    logic        badpar;
    logic        stomp;
    logic        needcpl;
    logic        more;
    logic [1:0]  cls;
    logic [7:0]  idx;
    logic        route;
    logic        sdrop;
    logic        ireq;
    logic        mcls0;
    logic [11:0] bcnt;
    logic [15:0] rid;
    logic [7:0]  csa_lo;
    logic [31:0] csa_hi;
    logic [3:0]  seq;
    logic [31:0] addr;
    logic [63:0] data;
  } pcix_cmd_t;

  typedef struct packed {
    up_kind_t    kind;
    logic        rd;
    logic        derr;
    logic [3:0]  seq;
    logic [31:0] addr;
    logic [31:0] data;
  } up_t;

  typedef struct packed {
    lo_kind_t    kind;
    logic        derr;
    logic [3:0]  seq;
    logic [31:0] data;
    logic [63:0] iinfo;
  } lout_t;
endpackage

// ==== test/lpx_pcix_far.sv ====
// PCI-X far-side model: takes bridge commands with prompt or stalling ready
`timescale 1ns/100ps
module lpx_pcix_far
  import lpx_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      nrst,
  input  wire logic      slow,
  input  wire logic      px_valid,
  input  wire pcix_cmd_t px_cmd,
  output logic           px_ready
);
  pcix_cmd_t  q[$];
  logic [2:0] stall_r;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stall_r  <= 3'h0;
      px_ready <= 1'b0;
    end else begin
      stall_r  <= stall_r + 3'h1;
      // Slow mode: ready two cycles in eight, so held-off commands get exercised
      px_ready <= !slow || (stall_r[2:1] == 2'h3);
    end
  end

  always @(posedge core_clk) begin
    if (nrst && px_valid === 1'b1) q.push_back(px_cmd);
  end
endmodule

// ==== test/tb.sv ====
// Self-checking bench of the link to PCI-X bridge
`timescale 1ns/100ps
module tb;
  import lpx_pkg::*;
  logic core_clk, nrst, link_clk, avs_read, avs_write, avs_waitrequest, slow;
  logic lk_valid, lk_ready, lo_valid, px_valid, px_ready, up_valid, up_ready;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, v, a, dt, rnd;
  logic [63:0] ei;
  logic [2:0]  ctl;
  link_req_t   lk_req, r;
  lout_t       lo_pkt, o;
  pcix_cmd_t   px_cmd, g, x;
  up_t         up_in, u;
  lout_t       lo_q[$];
  space_t      sps[3] = '{SP_MEM, SP_CFG, SP_IO};
  int          mismatches, samples_checked;

  lpx_bridge dut (.core_clk(core_clk), .nrst(nrst), .link_clk(link_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lk_valid(lk_valid), .lk_req(lk_req), .lk_ready(lk_ready),
    .lo_valid(lo_valid), .lo_pkt(lo_pkt), .px_valid(px_valid), .px_cmd(px_cmd), .px_ready(px_ready),
    .up_valid(up_valid), .up_in(up_in), .up_ready(up_ready));
  lpx_pcix_far u_far (.core_clk(core_clk), .nrst(nrst), .slow(slow), .px_valid(px_valid),
    .px_cmd(px_cmd), .px_ready(px_ready));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end
  always @(posedge link_clk) begin
    if (lo_valid === 1'b1) lo_q.push_back(lo_pkt);
  end

  function automatic logic [31:0] rn();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction
  // Reference translation of a link response
  function automatic pcix_cmd_t xlate(link_req_t q, logic [2:0] c);
    pcix_cmd_t y;
    logic bad;
    y = '0;
    y.ro = q.ro;
    bad = (q.err == ER_DATA) || q.derr;
    if (q.err == ER_TABORT || q.err == ER_MABORT) begin
      y.kind = PX_SCM;
      y.cls = CLS_BRIDGE;
      y.idx = (q.err == ER_TABORT) ? IDX_TABORT : IDX_MABORT;
    end else if (q.kind == LK_RD_RESP) begin
      y.kind = PX_SRC;
      y.stomp = bad & c[CTL_ECC];
      y.badpar = bad;
    end else if (q.err == ER_DATA && c[CTL_PERR]) begin
      y.kind = PX_SCM;
      y.cls = CLS_BRIDGE;
      y.idx = IDX_DERR;
    end else begin
      y.kind = PX_IWC;
      y.perr = q.derr & c[CTL_PERR];
    end
    return y;
  endfunction

  task automatic fail(input string m);
    mismatches++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [63:0] gv, input logic [63:0] ev, input string m);
    samples_checked++;
    if (gv !== ev) fail($sformatf("%s got %0h exp %0h", m, gv, ev));
  endtask
  task automatic chk_reg(input logic [31:0] gv, input logic [31:0] ev);
    samples_checked++;
    if (gv !== ev) fail($sformatf("register got %0h exp %0h", gv, ev));
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic av(input logic wr, input logic [4:0] ad, input logic [31:0] wd, output logic [31:0] rv);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address   <= ad;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rv = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 100) fail("avalon hang");
  endtask
  task automatic lk_send(input link_req_t q);
    int n;
    n = 0;
    @(posedge link_clk);
    lk_req   <= q;
    lk_valid <= 1'b1;
    do begin
      @(posedge link_clk);
      n++;
    end while (lk_ready !== 1'b1 && n < 300);
    lk_valid <= 1'b0;
    if (n >= 300) fail("link hang");
  endtask
  task automatic up_send(input up_t q);
    int n;
    n = 0;
    @(posedge core_clk);
    up_in    <= q;
    up_valid <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (up_ready !== 1'b1 && n < 300);
    up_valid <= 1'b0;
    if (n >= 300) fail("upstream hang");
  endtask
  task automatic get_px(output pcix_cmd_t c);
    int n;
    n = 0;
    while (u_far.q.size() == 0 && n < 500) begin
      @(posedge core_clk);
      n++;
    end
    c = '0;
    if (u_far.q.size() == 0) fail("no pcix command");
    else c = u_far.q.pop_front();
  endtask
  task automatic get_lo(output lout_t c);
    int n;
    n = 0;
    while (lo_q.size() == 0 && n < 300) begin
      @(posedge link_clk);
      n++;
    end
    c = '0;
    if (lo_q.size() == 0) fail("no link output");
    else c = lo_q.pop_front();
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    fail("watchdog");
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, avs_read, avs_write, lk_valid, up_valid, slow} = 6'h00;
    avs_address = 5'h00;
    avs_writedata = 32'h0000_0000;
    lk_req = '0;
    up_in = '0;
    rnd = 32'h0000_0036;
    // Short reset; the bridge stretches it toward the link side
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    av(1'b0, OFS_CTRL, 32'h0, rd);
    chk_reg(rd, {29'h0, CTRL_RST});
    av(1'b0, OFS_MBASE, 32'h0, rd);
    chk_reg(rd, {MBASE_RST, 20'h0});
    av(1'b1, 5'h0C, 32'hFFFF_FFFF, rd);
    av(1'b0, 5'h0C, 32'h0, rd);
    chk_reg(rd, 32'h0000_0000);
    av(1'b1, OFS_MBASE, 32'hFEE0_0ABC, rd);
    av(1'b0, OFS_MBASE, 32'h0, rd);
    chk_reg(rd, 32'hFEE0_0000);
    for (int c = 0; c < 2; c++) begin
      ctl = c ? 3'h6 : CTRL_RST;
      slow <= c[0];
      av(1'b1, OFS_CTRL, {29'h0, ctl}, rd);
      for (int i = 0; i < 16; i++) begin
        v = rn();
        r = '0;
        r.kind = lk_kind_t'({1'b0, i[3]});
        r.err = err_t'(i[2:1]);
        r.derr = i[0];
        r.ro = v[0];
        lk_send(r);
        get_px(g);
        x = xlate(r, ctl);
        chk(g.kind, x.kind, "kind");
        if (x.kind == PX_SRC) chk({g.ro, g.badpar, g.stomp}, {x.ro, x.badpar, x.stomp}, "src");
        if (x.kind == PX_IWC) chk(g.perr, x.perr, "perr");
        if (x.kind == PX_SCM) chk({g.cls, g.idx}, {x.cls, x.idx}, "class index");
      end
    end
    slow <= 1'b0;
    av(1'b1, OFS_CTRL, {29'h0, CTRL_RST}, rd);
    for (int c = 1; c >= 0; c--) begin
      r = '0;
      r.kind = LK_WRITE;
      r.posted = 1'b1;
      r.space = SP_XCFG;
      r.chain = c[0];
      r.addr = rn();
      r.data = {rn(), rn()};
      r.ppw = r.addr[9];
      r.coh = r.addr[10];
      lk_send(r);
      get_px(g);
      chk(g.kind, PX_DIMH, "dim kind");
      chk({g.ro, g.nosnoop}, {r.ppw, !r.coh}, "dim attr");
      chk({g.mcls0, g.route, g.sdrop, g.ireq}, r.addr[5:2], "dim route");
      chk({g.bcnt, g.rid}, {r.addr[27:24], r.data[23:0]}, "dim count id");
      chk({g.csa_hi, g.csa_lo}, {r.data[63:32], r.data[31:24]}, "dim csa");
      r.chain = 1'b0;
      r.space = c ? SP_XCFG : SP_MEM;
      r.data = {rn(), rn()};
      lk_send(r);
      get_px(g);
      chk(g.kind, c ? PX_DIMD : PX_PMW, "dim tail");
      if (c) chk(g.data, r.data, "dim payload");
      else chk({g.ro, g.nosnoop}, {r.ppw, !r.coh}, "pmw attr");
    end
    for (int s = 0; s < 3; s++) begin
      r = '0;
      r.kind = LK_WRITE;
      r.space = sps[s];
      r.addr = rn();
      r.data = {rn(), rn()};
      lk_send(r);
      get_px(g);
      chk(g.kind, (sps[s] == SP_MEM) ? PX_PMW : PX_SWR, "np write kind");
      repeat (30) @(posedge core_clk);
      chk(lo_q.size(), 0, "early done");
      u = '0;
      u.kind = UP_CPL;
      u.seq = g.seq;
      u.derr = r.data[0];
      up_send(u);
      get_lo(o);
      chk({o.kind, o.derr, o.seq}, {LO_TGT_DONE, u.derr, u.seq}, "done kind");
    end
    r = '0;
    r.kind = LK_READ;
    r.space = SP_CFG;
    r.seq = 4'h3;
    r.addr = rn();
    lk_send(r);
    get_px(g);
    chk(g.kind, PX_SRR, "cfg read");
    r.space = SP_IO;
    fork
      lk_send(r);
    join_none
    repeat (40) @(posedge core_clk);
    chk(u_far.q.size(), 0, "same sequence overtook");
    av(1'b0, OFS_STAT, 32'h0, rd);
    chk_reg(rd, 32'h0008_0002);
    for (int k = 0; k < 2; k++) begin
      u = '0;
      u.kind = UP_CPL;
      u.rd = 1'b1;
      u.seq = 4'h3;
      u.data = rn();
      up_send(u);
      get_lo(o);
      chk({o.kind, o.data}, {LO_RD_RESP, u.data}, "read answer");
      if (k == 0) get_px(g);
      if (k == 0) chk(g.kind, PX_SRR, "io read after");
    end
    wait fork;
    for (int i = 0; i < 5; i++) begin
      v = rn();
      a = (i == 4) ? 32'h1234_5678 : {12'hFEE, v[19:0]};
      v = rn();
      // Request_eoi kept zero, message type fixed or lowest-priority only
      dt = {16'h0000, 1'b0, v[14:11], 2'b00, i[0], v[7:0]};
      u = '0;
      u.kind = UP_MWR;
      u.addr = a;
      u.data = dt;
      up_send(u);
      ei = '0;
      ei[6:2] = {a[2], dt[15], dt[10:8]};
      ei[31:8] = {INTR_HI, dt[7:0], a[19:12]};
      ei[55:32] = {dt[14:11], a[3], a[30:20], a[11:4]};
      if (i == 4) repeat (40) @(posedge core_clk);
      if (i == 4) chk(lo_q.size(), 0, "msi outside window");
      else get_lo(o);
      if (i < 4) chk({o.kind, o.iinfo[55:2]}, {LO_INTR, ei[55:2]}, "interrupt info");
    end
    conclude();
  end
endmodule
